/* alpd_detector.sv */
`timescale 1ns/1ps
module alpd_detector
  import alpd_pkg::*;
#(
  parameter int MS_CYCLES = STEP_CYCLES
) (
  // Clock and reset
  input  wire logic            clk_in,
  input  wire logic            sys_rst_in,
  // Register port
  input  wire logic            reg_wr_in,
  input  wire logic [7:0]      reg_addr_in,
  input  wire logic [7:0]      reg_wdata_in,
  output logic      [7:0]      reg_rdata_out,
  // Samples from the converter, 8g scale
  input  wire logic            sample_valid_in,
  input  wire alpd_sample_type sample_in,
  // Interrupt pins
  output logic                 interrupt_out_a_out,
  output logic                 interrupt_out_b_out
);

  logic [1:0] mode_q;
  logic [7:0] ctrl1_q, ctrl2_q, lth_q, pth_q, pdur_q, lat_q, win_q;
  logic [1:0] clr_q;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      mode_q  <= 2'h0;
      clr_q   <= 2'h0;
      ctrl1_q <= CTRL_RST;
      ctrl2_q <= CTRL_RST;
      lth_q   <= TH_RST;
      pth_q   <= TH_RST;
      pdur_q  <= PDUR_RST;
      lat_q   <= LAT_RST;
      win_q   <= WIN_RST;
    end else if (reg_wr_in) begin
      unique case (reg_addr_in)
        MODE_ADDR:  mode_q  <= reg_wdata_in[1:0];
        CLEAR_ADDR: clr_q   <= reg_wdata_in[1:0];
        CTRL1_ADDR: ctrl1_q <= reg_wdata_in;
        CTRL2_ADDR: ctrl2_q <= reg_wdata_in;
        LTH_ADDR:   lth_q   <= reg_wdata_in;
        PTH_ADDR:   pth_q   <= reg_wdata_in;
        PDUR_ADDR:  pdur_q  <= reg_wdata_in;
        LAT_ADDR:   lat_q   <= reg_wdata_in;
        WIN_ADDR:   win_q   <= reg_wdata_in;
        default: ;
      endcase
    end
  end

  logic       threshold_option, lpol, ppol, interrupt_pin_swap;
  logic [1:0] route;
  logic [2:0] dis, en;
  logic       lvl_mode, pul_mode;
  assign threshold_option    = ctrl1_q[THRESHOLD_OPTION_BIT];
  assign dis      = ctrl1_q[XDIS_BIT +: 3];
  assign en       = ~dis;
  assign route    = ctrl1_q[INTERRUPT_ASSIGNMENT_LSB +: 2];
  assign interrupt_pin_swap   = ctrl1_q[INTERRUPT_PIN_SWAP_BIT];
  assign lpol     = ctrl2_q[LPOL_BIT];
  assign ppol     = ctrl2_q[PPOL_BIT];
  // Pulse mode keeps the level path alive as well
  assign lvl_mode = mode_q[1];
  assign pul_mode = (mode_q == MODE_PULSE);

  // Magnitude mode ignores the top threshold bit; host keeps it 0
  function automatic logic over_f(input logic [7:0] v, th,
                                  input logic opt);
    logic [7:0] mag;
    mag = v[7] ? 8'(-v) : v;
    if (opt) over_f = $signed(v) > $signed(th);
    else     over_f = {1'b0, mag} > {2'h0, th[6:0]};
  endfunction
  function automatic logic under_f(input logic [7:0] v, th,
                                   input logic opt);
    logic [7:0] mag;
    mag = v[7] ? 8'(-v) : v;
    if (opt) under_f = $signed(v) < $signed(th);
    else     under_f = {1'b0, mag} < {2'h0, th[6:0]};
  endfunction

  alpd_sample_type samp_q;
  logic            eval_q;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      samp_q <= '0;
      eval_q <= 1'b0;
    end else begin
      eval_q <= sample_valid_in;
      if (sample_valid_in) samp_q <= sample_in;
    end
  end

  logic [2:0] lo, lu, po, pu;
  logic [7:0] ax [3];
  assign ax[0] = samp_q.x;
  assign ax[1] = samp_q.y;
  assign ax[2] = samp_q.z;
  for (genvar i = 0; i < 3; i++) begin : g_axis
    assign lo[i] = over_f(ax[i], lth_q, threshold_option);
    assign lu[i] = under_f(ax[i], lth_q, threshold_option);
    assign po[i] = over_f(ax[i], pth_q, threshold_option);
    assign pu[i] = under_f(ax[i], pth_q, threshold_option);
  end

  // Disabled axes neither satisfy nor block
  logic [2:0] lvl_axes;
  logic       lvl_evt, any_over, all_under;
  assign lvl_axes  = (lpol ? lu : lo) & en;
  assign lvl_evt   = lvl_mode & eval_q & (lpol ?
                     (&(lu | dis) & |en) : |(lo & en));
  assign any_over  = |(po & en);
  assign all_under = &(pu | dis) & |en;

  // Millisecond step for the pulse timers only
  logic [15:0] div_q;
  logic        tick;
  assign tick = (div_q == 16'(MS_CYCLES - 1));
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in)  div_q <= 16'h0000;
    else if (tick)   div_q <= 16'h0000;
    else             div_q <= div_q + 16'h0001;
  end

  // Clear routing follows the pin assignment except in ROUTE_SD, where the B bit clears both pins
  logic clr_lvl, clr_pul, rst_fsm;
  assign clr_lvl = (route == ROUTE_PL) ? clr_q[CLR_B_BIT]
                                       : clr_q[CLR_A_BIT];
  assign clr_pul = (route == ROUTE_PL) ? clr_q[CLR_A_BIT]
                                       : clr_q[CLR_B_BIT];
  assign rst_fsm = !pul_mode | (route == ROUTE_SD & clr_pul);

  alpd_state_type st_q;
  logic [7:0]     cnt_q;
  logic [2:0]     hit_q;
  logic           p1_evt, p2_evt, ff_evt;
  assign p1_evt = (st_q == P_FIRST) & !any_over & !ppol;
  assign p2_evt = (st_q == P_SECOND) & !any_over;
  assign ff_evt = (st_q == P_FALL) & all_under
                  & (cnt_q > lat_q);

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_q  <= P_IDLE;
      cnt_q <= 8'h00;
      hit_q <= 3'h0;
    end else if (rst_fsm) begin
      st_q  <= P_IDLE;
      cnt_q <= 8'h00;
    end else begin
      if (tick && cnt_q != 8'hff) cnt_q <= cnt_q + 8'h01;
      unique case (st_q)
        P_IDLE: begin
          cnt_q <= 8'h00;
          if (ppol && all_under) st_q <= P_FALL;
          else if (!ppol && any_over) begin
            st_q  <= P_FIRST;
            hit_q <= po & en;
          end
        end
        P_FIRST: begin
          if (!any_over) begin
            cnt_q <= 8'h00;
            st_q  <= (win_q == 8'h00) ? P_IDLE : P_LAT;
          end else if (cnt_q >= pdur_q) st_q <= P_WAITLO;
        end
        P_LAT: if (cnt_q >= lat_q) begin
          cnt_q <= 8'h00;
          st_q  <= P_WIN;
        end
        P_WIN: begin
          if (any_over) begin
            cnt_q <= 8'h00;
            st_q  <= P_SECOND;
          end else if (cnt_q >= win_q) st_q <= P_IDLE;
        end
        P_SECOND: begin
          if (!any_over) st_q <= P_IDLE;
          else if (cnt_q >= pdur_q) st_q <= P_WAITLO;
        end
        P_FALL: begin
          if (!all_under) st_q <= P_IDLE;
          else if (ff_evt) st_q <= P_WAITLO;
        end
        P_WAITLO: begin
          cnt_q <= 8'h00;
          if (ppol ? !all_under : !any_over) st_q <= P_IDLE;
        end
      endcase
    end
  end

  // Sticky flags; a new event beats a clear in the same cycle
  logic       lvl_f_q, p1_f_q, p2_f_q, ff_f_q;
  logic [2:0] lsrc_q, psrc_q;
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      lvl_f_q <= 1'b0;
      lsrc_q  <= 3'h0;
    end else begin
      lvl_f_q <= lvl_evt | (lvl_f_q & !clr_lvl);
      lsrc_q  <= (lvl_evt ? lvl_axes : 3'h0)
                 | (lsrc_q & {3{!clr_lvl}});
    end
  end
  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      p1_f_q <= 1'b0;
      p2_f_q <= 1'b0;
      ff_f_q <= 1'b0;
      psrc_q <= 3'h0;
    end else begin
      p1_f_q <= p1_evt | (p1_f_q & !clr_pul);
      p2_f_q <= p2_evt | (p2_f_q & !clr_pul);
      ff_f_q <= ff_evt | (ff_f_q & !clr_pul);
      psrc_q <= (p1_evt ? hit_q : 3'h0)
                | (psrc_q & {3{!clr_pul}});
    end
  end

  // With a second window the pulse pin waits for the second pulse
  logic pul_any, pin_a, pin_b;
  assign pul_any = ff_f_q | ((win_q == 8'h00) ? p1_f_q : p2_f_q);
  always_comb begin
    unique case (route)
      ROUTE_PL: begin
        pin_a = pul_any;
        pin_b = lvl_f_q;
      end
      ROUTE_SD: begin
        pin_a = p1_f_q;
        pin_b = pul_any;
      end
      default: begin
        pin_a = lvl_f_q;
        pin_b = pul_any;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      interrupt_out_a_out <= 1'b0;
      interrupt_out_b_out <= 1'b0;
    end else begin
      interrupt_out_a_out <= pin_a;
      interrupt_out_b_out <= pin_b;
    end
  end

  logic [7:0] src;
  assign src = {lsrc_q[0], lsrc_q[1], lsrc_q[2],
                psrc_q[0], psrc_q[1], psrc_q[2],
                interrupt_pin_swap ? interrupt_out_a_out : interrupt_out_b_out,
                interrupt_pin_swap ? interrupt_out_b_out : interrupt_out_a_out};

  always_ff @(posedge clk_in or posedge sys_rst_in) begin
    if (sys_rst_in) reg_rdata_out <= 8'h00;
    else begin
      unique case (reg_addr_in)
        SRC_ADDR:   reg_rdata_out <= src;
        MODE_ADDR:  reg_rdata_out <= {6'h00, mode_q};
        CLEAR_ADDR: reg_rdata_out <= {6'h00, clr_q};
        CTRL1_ADDR: reg_rdata_out <= ctrl1_q;
        CTRL2_ADDR: reg_rdata_out <= ctrl2_q;
        LTH_ADDR:   reg_rdata_out <= lth_q;
        PTH_ADDR:   reg_rdata_out <= pth_q;
        PDUR_ADDR:  reg_rdata_out <= pdur_q;
        LAT_ADDR:   reg_rdata_out <= lat_q;
        WIN_ADDR:   reg_rdata_out <= win_q;
        default:    reg_rdata_out <= 8'h00;
      endcase
    end
  end

  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);

  lvl_sets_pin_a: assert property ((lvl_evt && route == ROUTE_LP)
    |=> lvl_f_q ##1 interrupt_out_a_out)
    else $error("level event not latched");
  lvl_holds_a: assert property ((lvl_f_q && !clr_lvl)
    |=> lvl_f_q) else $error("level flag dropped");
  mode_gate_a: assert property (!mode_q[1] |=> $stable(lvl_f_q)
    || !lvl_f_q) else $error("level set outside mode");
  or_cond_a: assert property ((lvl_evt && !lpol)
    |-> |(lo & en)) else $error("or condition violated");
  and_cond_a: assert property ((lvl_evt && lpol)
    |-> &(lu | dis)) else $error("and condition violated");
  all_dis_a: assert property ((&dis) |-> !lvl_evt
    && !any_over) else $error("disabled axes detected");
  single_a: assert property (p1_evt |=> p1_f_q)
    else $error("single pulse lost");
  win_zero_a: assert property ((p1_evt && win_q == 8'h00
    && !rst_fsm) |=> st_q == P_IDLE)
    else $error("window zero not single");
  freefall_a: assert property ($rose(ff_f_q) |->
    $past(cnt_q) > $past(lat_q)) else $error("freefall early");
  double_a: assert property ($rose(p2_f_q) |->
    $past(st_q) == P_SECOND) else $error("double out of order");
  dur_out_a: assert property ((st_q == P_FIRST && any_over
    && cnt_q >= pdur_q && !rst_fsm) |=> st_q == P_WAITLO)
    else $error("long pulse not dropped");
  tick_gap_a: assert property (tick |=> !tick)
    else $error("tick too frequent");
  single_pin_a: assert property ((p1_evt && win_q == 8'h00
    && route == ROUTE_LP) |=> ##1 interrupt_out_b_out)
    else $error("single pulse pin missing");
  first_pin_a: assert property ((route == ROUTE_SD
    && $rose(p1_f_q)) |=> interrupt_out_a_out)
    else $error("first pulse pin missing");

  cov_level: cover property (lvl_evt ##1 lvl_f_q);
  cov_single: cover property (p1_evt && win_q == 8'h00);
  cov_double: cover property (p2_evt);
  cov_freefall: cover property (ff_evt);
  cov_first_pin: cover property (route == ROUTE_SD && p1_evt);

endmodule // alpd_detector

/* alpd_pkg.sv */
package alpd_pkg;
  // Register offsets
  localparam logic [7:0] MODE_ADDR   = 8'h16;
  localparam logic [7:0] CLEAR_ADDR  = 8'h17;
  localparam logic [7:0] CTRL1_ADDR  = 8'h18;
  localparam logic [7:0] CTRL2_ADDR  = 8'h19;
  localparam logic [7:0] LTH_ADDR    = 8'h1a;
  localparam logic [7:0] PTH_ADDR    = 8'h1b;
  localparam logic [7:0] PDUR_ADDR   = 8'h1c;
  localparam logic [7:0] LAT_ADDR    = 8'h1d;
  localparam logic [7:0] WIN_ADDR    = 8'h1e;
  localparam logic [7:0] SRC_ADDR    = 8'h0a;
  // Reset values
  localparam logic [7:0] CTRL_RST    = 8'h00;
  localparam logic [7:0] TH_RST      = 8'h00;
  localparam logic [7:0] PDUR_RST    = 8'h01;
  localparam logic [7:0] LAT_RST     = 8'h01;
  localparam logic [7:0] WIN_RST     = 8'h00;
  // Field positions
  localparam int INTERRUPT_PIN_SWAP_BIT  = 0;
  localparam int INTERRUPT_ASSIGNMENT_LSB  = 1;
  localparam int XDIS_BIT    = 3;
  localparam int THRESHOLD_OPTION_BIT   = 6;
  localparam int LPOL_BIT    = 0;
  localparam int PPOL_BIT    = 1;
  localparam int CLR_A_BIT   = 0;
  localparam int CLR_B_BIT   = 1;
  // Mode and routing codes
  localparam logic [1:0] MODE_LEVEL  = 2'h2;
  localparam logic [1:0] MODE_PULSE  = 2'h3;
  localparam logic [1:0] ROUTE_LP    = 2'h0;
  localparam logic [1:0] ROUTE_PL    = 2'h1;
  localparam logic [1:0] ROUTE_SD    = 2'h2;
  // Timer step
  localparam int CLK_PERIOD_NS = 100;
  localparam int STEP_MS       = 1;
  localparam int STEP_CYCLES   = STEP_MS * 1000000 / CLK_PERIOD_NS;

  typedef struct packed {
    logic [7:0] x;
    logic [7:0] y;
    logic [7:0] z;
  } alpd_sample_type;

  typedef enum logic [2:0] {
    P_IDLE, P_FIRST, P_LAT, P_WIN, P_SECOND, P_FALL, P_WAITLO
  } alpd_state_type;
endpackage

/* alpd_host.sv */
`timescale 1ns/1ps
module alpd_host
  import alpd_pkg::*;
(
  // Clock
  input  wire logic            clk_in,
  // Register port towards the device
  output logic                 reg_wr_out,
  output logic      [7:0]      reg_addr_out,
  output logic      [7:0]      reg_wdata_out,
  input  wire logic [7:0]      reg_rdata_in,
  // Sample stream
  output logic                 sample_valid_out,
  output alpd_sample_type      sample_out
);
  initial begin
    reg_wr_out = 1'b0;
    reg_addr_out = 8'h00;
    reg_wdata_out = 8'h00;
    sample_valid_out = 1'b0;
    sample_out = '0;
  end

  // Data lines are scrambled once unqualified, so stale values never help
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_in);
    #1;
    reg_wr_out = 1'b1;
    reg_addr_out = a;
    reg_wdata_out = d;
    @(posedge clk_in);
    #1;
    reg_wr_out = 1'b0;
    reg_wdata_out = ~d;
  endtask

  // Read data is registered one edge behind the address
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk_in);
    #1;
    reg_addr_out = a;
    @(posedge clk_in);
    #1;
    d = reg_rdata_in;
  endtask

  task automatic smp(input logic [7:0] x, input logic [7:0] y,
                     input logic [7:0] z);
    @(posedge clk_in);
    #1;
    sample_valid_out = 1'b1;
    sample_out = '{x: x, y: y, z: z};
    @(posedge clk_in);
    #1;
    sample_valid_out = 1'b0;
    sample_out = ~sample_out;
  endtask
endmodule // alpd_host

/* test_accel_level_pulse_detector.sv */
`timescale 1ns/1ps
module test_accel_level_pulse_detector
  import alpd_pkg::*;
;
  logic            clk_in;
  logic            sys_rst_in;
  logic            reg_wr;
  logic [7:0]      reg_addr;
  logic [7:0]      reg_wdata;
  logic [7:0]      reg_rdata;
  logic            sample_valid;
  alpd_sample_type sample;
  logic            int_a;
  logic            int_b;
  int              fail_count;
  int              total_checks;
  int              cycles;
  logic [7:0]      ra [9] = '{8'h18, 8'h19, 8'h1a, 8'h1b, 8'h1c, 8'h1d,
                              8'h1e, 8'h0a, 8'h20};
  logic [7:0]      rv [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01,
                              8'h00, 8'h00, 8'h00};

  alpd_detector #(.MS_CYCLES(8)) i_alpd_detector (
    .clk_in              (clk_in),
    .sys_rst_in          (sys_rst_in),
    .reg_wr_in           (reg_wr),
    .reg_addr_in         (reg_addr),
    .reg_wdata_in        (reg_wdata),
    .reg_rdata_out       (reg_rdata),
    .sample_valid_in     (sample_valid),
    .sample_in           (sample),
    .interrupt_out_a_out (int_a),
    .interrupt_out_b_out (int_b)
  );

  alpd_host i_alpd_host (
    .clk_in           (clk_in),
    .reg_wr_out       (reg_wr),
    .reg_addr_out     (reg_addr),
    .reg_wdata_out    (reg_wdata),
    .reg_rdata_in     (reg_rdata),
    .sample_valid_out (sample_valid),
    .sample_out       (sample)
  );

  initial begin
    clk_in = 1'b0;
    forever #50 clk_in = ~clk_in;
  end

  task automatic test_done();
    if (fail_count == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Ceiling well above the few hundred cycles the sequence needs
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      test_done();
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      fail_count++;
    end
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] v;
    i_alpd_host.rd(a, v);
    check(v, exp);
  endtask

  // Checks the pin after n edges
  task automatic pin_after(input bit b, input int n, input logic exp);
    repeat (n) @(posedge clk_in);
    #2;
    check({7'h00, b ? int_b : int_a}, {7'h00, exp});
  endtask

  // Waits a bounded time for the pin to rise
  task automatic pin_rises(input bit b, input int n);
    for (int k = 0; k < n; k++) begin
      @(posedge clk_in);
      #2;
      if ((b ? int_b : int_a) === 1'b1)
        break;
    end
    check({7'h00, b ? int_b : int_a}, 8'h01);
  endtask

  task automatic clear_pins();
    i_alpd_host.wr(CLEAR_ADDR, 8'h03);
    i_alpd_host.wr(CLEAR_ADDR, 8'h00);
  endtask

  initial begin
    fail_count = 0;
    total_checks = 0;
    cycles = 0;
    sys_rst_in = 1'b1;
    repeat (3) @(posedge clk_in);
    #1;
    sys_rst_in = 1'b0;
    for (int i = 0; i < 9; i++)
      rdchk(ra[i], rv[i]);
    i_alpd_host.wr(LTH_ADDR, 8'h2f);
    i_alpd_host.wr(SRC_ADDR, 8'hff);
    rdchk(LTH_ADDR, 8'h2f);
    rdchk(SRC_ADDR, 8'h00);
    // Motion by magnitude, one axis over
    i_alpd_host.wr(MODE_ADDR, 8'h02);
    i_alpd_host.smp(8'h40, 8'h00, 8'h00);
    pin_after(0, 1, 1'b0);
    pin_after(0, 1, 1'b1);
    rdchk(SRC_ADDR, 8'h81);
    i_alpd_host.smp(8'h00, 8'h00, 8'h00);
    pin_after(0, 4, 1'b1);
    clear_pins();
    pin_after(0, 2, 1'b0);
    i_alpd_host.smp(8'hc0, 8'h00, 8'h00);
    pin_after(0, 2, 1'b1);
    i_alpd_host.smp(8'h00, 8'h00, 8'h00);
    clear_pins();
    // Signed compare: -64 is not above 47
    i_alpd_host.wr(CTRL1_ADDR, 8'h40);
    i_alpd_host.smp(8'hc0, 8'h00, 8'h00);
    pin_after(0, 4, 1'b0);
    // Disabled axis is neutral
    i_alpd_host.wr(CTRL1_ADDR, 8'h08);
    i_alpd_host.smp(8'h40, 8'h00, 8'h00);
    pin_after(0, 4, 1'b0);
    i_alpd_host.wr(CTRL1_ADDR, 8'h38);
    i_alpd_host.smp(8'h40, 8'h40, 8'h40);
    pin_after(0, 4, 1'b0);
    // Level routed to pin B, source pin bits swapped
    i_alpd_host.wr(CTRL1_ADDR, 8'h03);
    i_alpd_host.smp(8'h40, 8'h00, 8'h00);
    pin_after(1, 2, 1'b1);
    pin_after(0, 0, 1'b0);
    rdchk(SRC_ADDR, 8'h81);
    clear_pins();
    pin_after(1, 2, 1'b0);
    // Freefall: all enabled axes under
    i_alpd_host.wr(CTRL1_ADDR, 8'h00);
    i_alpd_host.wr(LTH_ADDR, 8'h07);
    i_alpd_host.wr(CTRL2_ADDR, 8'h01);
    i_alpd_host.smp(8'h02, 8'hfe, 8'h03);
    pin_after(0, 2, 1'b1);
    i_alpd_host.smp(8'h02, 8'h02, 8'h10);
    clear_pins();
    pin_after(0, 4, 1'b0);
    i_alpd_host.wr(MODE_ADDR, 8'h00);
    i_alpd_host.smp(8'h02, 8'h02, 8'h02);
    pin_after(0, 4, 1'b0);
    // Pulse mode, level kept quiet by a high threshold
    i_alpd_host.wr(CTRL2_ADDR, 8'h00);
    i_alpd_host.wr(LTH_ADDR, 8'h7f);
    // Threshold first, so the idle samples never look like a pulse
    i_alpd_host.wr(PTH_ADDR, 8'h20);
    i_alpd_host.wr(PDUR_ADDR, 8'h02);
    i_alpd_host.wr(MODE_ADDR, 8'h03);
    i_alpd_host.smp(8'h40, 8'h00, 8'h00);
    i_alpd_host.smp(8'h00, 8'h00, 8'h00);
    pin_rises(1, 30);
    rdchk(SRC_ADDR, 8'h12);
    clear_pins();
    i_alpd_host.smp(8'h00, 8'h40, 8'h00);
    repeat (40) @(posedge clk_in);
    i_alpd_host.smp(8'h00, 8'h00, 8'h00);
    pin_after(1, 30, 1'b0);
    // Freefall in pulse mode needs more than the latency
    i_alpd_host.wr(CTRL2_ADDR, 8'h02);
    i_alpd_host.smp(8'h01, 8'h01, 8'h01);
    pin_after(1, 3, 1'b0);
    pin_rises(1, 40);
    i_alpd_host.smp(8'h40, 8'h40, 8'h40);
    clear_pins();
    // Double pulse, first and second on separate pins
    i_alpd_host.wr(MODE_ADDR, 8'h02);
    i_alpd_host.wr(CTRL2_ADDR, 8'h00);
    i_alpd_host.wr(CTRL1_ADDR, 8'h04);
    i_alpd_host.wr(WIN_ADDR, 8'h04);
    i_alpd_host.smp(8'h00, 8'h00, 8'h00);
    i_alpd_host.wr(MODE_ADDR, 8'h03);
    i_alpd_host.smp(8'h00, 8'h00, 8'h40);
    i_alpd_host.smp(8'h00, 8'h00, 8'h00);
    pin_rises(0, 30);
    rdchk(SRC_ADDR, 8'h05);
    pin_after(1, 20, 1'b0);
    i_alpd_host.smp(8'h00, 8'h40, 8'h00);
    i_alpd_host.smp(8'h00, 8'h00, 8'h00);
    pin_rises(1, 30);
    clear_pins();
    pin_after(0, 2, 1'b0);
    test_done();
  end
endmodule // test_accel_level_pulse_detector
